// ===== rtl/dpm_defines.svh
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define DPM_WORD_W        36
`define DPM_PIN_W         41

// ==========================================================================
// Positions inside the sampled pin vector of one port
// ==========================================================================
`define DPM_PIN_BUS_LSB   0
`define DPM_PIN_BUS_MSB   35
`define DPM_PIN_SEL       36
`define DPM_PIN_STB       37
`define DPM_PIN_DIR       38
`define DPM_PIN_CS_N      39
`define DPM_PIN_CLK       40

// ==========================================================================
// Encodings and reset values
// ==========================================================================
`define DPM_A_DIR_WRITE   1'b1
`define DPM_B_DIR_WRITE   1'b0
`define DPM_CS_ACTIVE     1'b0
`define DPM_FULL_N_IDLE   1'b1
`define DPM_FULL_N_MAIL   1'b0
`define DPM_WORD_RST      36'h0_0000_0000
`define DPM_PIN_RST       41'h180_0000_0000 // Port clock high, chip select off
`define DPM_CLK_PREV_RST  1'h1
`define DPM_OE_RST        1'h0

`endif

// ===== rtl/dpm_pkg.sv
`include "dpm_defines.svh"

// ==========================================================================
// Shared types
// ==========================================================================
package dpm_pkg;

    // One mailbox or bus word
    typedef logic [`DPM_WORD_W-1:0] dpm_word_t;

    // All pins of one port, sampled together
    typedef logic [`DPM_PIN_W-1:0] dpm_pins_t;

endpackage : dpm_pkg

// ===== rtl/dpm_mailbox_top.sv
// Overview of operation
// - One 36-bit mailbox in each direction
// - Port A mailbox write stores port A bus
// - Port B mailbox write stores port B bus
// - Accepted write drives mailbox full flag low
// - Writes ignored while full flag is low
// - Driven data: FIFO word or mailbox by select
// - Port B mailbox read raises A-to-B flag
// - Port A mailbox read raises B-to-A flag
// - Reading never changes the stored word
`include "dpm_defines.svh"

module dpm_mailbox_top
    import dpm_pkg::*;
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    // Port A pins
    input  wire logic                   i_port_a_clock,
    input  wire logic                   i_port_a_chip_select_n,
    input  wire logic                   i_port_a_direction,
    input  wire logic                   i_port_a_transfer_strobe,
    input  wire logic                   i_port_a_mailbox_select,
    input  wire logic [`DPM_WORD_W-1:0] i_port_a_bus,
    output logic      [`DPM_WORD_W-1:0] o_port_a_bus,
    output logic                        o_port_a_bus_oe,
    output logic                        o_b_to_a_mail_full_n,
    // Port B pins
    input  wire logic                   i_port_b_clock,
    input  wire logic                   i_port_b_chip_select_n,
    input  wire logic                   i_port_b_direction,
    input  wire logic                   i_port_b_transfer_strobe,
    input  wire logic                   i_port_b_mailbox_select,
    input  wire logic [`DPM_WORD_W-1:0] i_port_b_bus,
    output logic      [`DPM_WORD_W-1:0] o_port_b_bus,
    output logic                        o_port_b_bus_oe,
    output logic                        o_a_to_b_mail_full_n,
    // FIFO output registers, from logic on this clock
    input  wire logic [`DPM_WORD_W-1:0] i_port_a_fifo_word,
    input  wire logic [`DPM_WORD_W-1:0] i_port_b_fifo_word
);

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    dpm_pins_t a_meta_q;
    dpm_pins_t a_sync_q;
    dpm_pins_t b_meta_q;
    dpm_pins_t b_sync_q;
    logic      a_clk_prev_q;
    logic      b_clk_prev_q;

    // Two stages on every pin of both ports
    // Reset loads idle levels: chip select off, port clock high
    // Clock seen high at release must fall before an edge counts
    // Chip select off keeps outputs undriven right after reset
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            a_meta_q <= `DPM_PIN_RST;
            a_sync_q <= `DPM_PIN_RST;
            b_meta_q <= `DPM_PIN_RST;
            b_sync_q <= `DPM_PIN_RST;
        end else begin
            a_meta_q <= {i_port_a_clock, i_port_a_chip_select_n, i_port_a_direction,
                         i_port_a_transfer_strobe, i_port_a_mailbox_select, i_port_a_bus};
            b_meta_q <= {i_port_b_clock, i_port_b_chip_select_n, i_port_b_direction,
                         i_port_b_transfer_strobe, i_port_b_mailbox_select, i_port_b_bus};
            a_sync_q <= a_meta_q;
            b_sync_q <= b_meta_q;
        end
    end

    // Previous port clock levels for edge detection
    // Reset level matches the synchroniser, so no false rise
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            a_clk_prev_q <= `DPM_CLK_PREV_RST;
            b_clk_prev_q <= `DPM_CLK_PREV_RST;
        end else begin
            a_clk_prev_q <= a_sync_q[`DPM_PIN_CLK];
            b_clk_prev_q <= b_sync_q[`DPM_PIN_CLK];
        end
    end

    // ======================================================================
    // Port decode
    // ======================================================================
    logic      a_rise;
    logic      b_rise;
    logic      a_sel_mail;
    logic      b_sel_mail;
    logic      a_mail_wr;
    logic      a_mail_rd;
    logic      b_mail_wr;
    logic      b_mail_rd;
    logic      a_read_dir;
    logic      b_read_dir;
    dpm_word_t a_bus_s;
    dpm_word_t b_bus_s;

    // Rising port clock edges seen in the system domain
    // One-cycle enable pulse per port clock rise
    assign a_rise = a_sync_q[`DPM_PIN_CLK] & ~a_clk_prev_q;
    assign b_rise = b_sync_q[`DPM_PIN_CLK] & ~b_clk_prev_q;

    // Selected, enabled mailbox access on each port
    assign a_sel_mail = (a_sync_q[`DPM_PIN_CS_N] == `DPM_CS_ACTIVE)
                      & a_sync_q[`DPM_PIN_STB] & a_sync_q[`DPM_PIN_SEL];
    assign b_sel_mail = (b_sync_q[`DPM_PIN_CS_N] == `DPM_CS_ACTIVE)
                      & b_sync_q[`DPM_PIN_STB] & b_sync_q[`DPM_PIN_SEL];

    // Direction per port; the two ports use opposite write levels
    assign a_read_dir = (a_sync_q[`DPM_PIN_DIR] != `DPM_A_DIR_WRITE);
    assign b_read_dir = (b_sync_q[`DPM_PIN_DIR] != `DPM_B_DIR_WRITE);

    // Write and read events on a port clock edge
    assign a_mail_wr = a_rise & a_sel_mail & ~a_read_dir;
    assign a_mail_rd = a_rise & a_sel_mail &  a_read_dir;
    assign b_mail_wr = b_rise & b_sel_mail & ~b_read_dir;
    assign b_mail_rd = b_rise & b_sel_mail &  b_read_dir;

    // Bus words aligned with the sampled controls
    // Same two-stage path, so bus and clock edge stay in step
    assign a_bus_s = a_sync_q[`DPM_PIN_BUS_MSB:`DPM_PIN_BUS_LSB];
    assign b_bus_s = b_sync_q[`DPM_PIN_BUS_MSB:`DPM_PIN_BUS_LSB];

    // ======================================================================
    // Mailbox storage
    // ======================================================================
    dpm_word_t a_to_b_mailbox_q;
    dpm_word_t b_to_a_mailbox_q;
    logic      a_to_b_full_n_q;
    logic      b_to_a_full_n_q;

    // A-to-B word; loaded only while empty, reads leave it alone
    // A write while full is dropped with no sign to the writer
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            a_to_b_mailbox_q <= `DPM_WORD_RST;
        end else if (a_mail_wr && a_to_b_full_n_q) begin
            a_to_b_mailbox_q <= a_bus_s;
        end
    end

    // B-to-A word; loaded only while empty, reads leave it alone
    // A write while full is dropped with no sign to the writer
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            b_to_a_mailbox_q <= `DPM_WORD_RST;
        end else if (b_mail_wr && b_to_a_full_n_q) begin
            b_to_a_mailbox_q <= b_bus_s;
        end
    end

    // A-to-B flag; an accepted write beats a same-cycle read
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            a_to_b_full_n_q <= `DPM_FULL_N_IDLE;
        end else if (a_mail_wr && a_to_b_full_n_q) begin
            a_to_b_full_n_q <= `DPM_FULL_N_MAIL;
        end else if (b_mail_rd) begin
            a_to_b_full_n_q <= `DPM_FULL_N_IDLE;
        end
    end

    // B-to-A flag; an accepted write beats a same-cycle read
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            b_to_a_full_n_q <= `DPM_FULL_N_IDLE;
        end else if (b_mail_wr && b_to_a_full_n_q) begin
            b_to_a_full_n_q <= `DPM_FULL_N_MAIL;
        end else if (a_mail_rd) begin
            b_to_a_full_n_q <= `DPM_FULL_N_IDLE;
        end
    end

    // Flags go out straight from their flip-flops
    assign o_a_to_b_mail_full_n = a_to_b_full_n_q;
    assign o_b_to_a_mail_full_n = b_to_a_full_n_q;

    // ======================================================================
    // Data outputs
    // ======================================================================
    dpm_word_t a_out_q;
    dpm_word_t b_out_q;
    logic      a_oe_q;
    logic      b_oe_q;

    // Port A drives while selected for read
    // Strobe does not gate the drive, only select and direction
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            a_oe_q  <= `DPM_OE_RST;
            a_out_q <= `DPM_WORD_RST;
        end else begin
            a_oe_q  <= (a_sync_q[`DPM_PIN_CS_N] == `DPM_CS_ACTIVE) & a_read_dir;
            a_out_q <= a_sync_q[`DPM_PIN_SEL] ? b_to_a_mailbox_q
                                              : i_port_a_fifo_word;
        end
    end

    // Port B drives while selected for read
    // Strobe does not gate the drive, only select and direction
    // Read level on this port is the opposite of port A
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            b_oe_q  <= `DPM_OE_RST;
            b_out_q <= `DPM_WORD_RST;
        end else begin
            b_oe_q  <= (b_sync_q[`DPM_PIN_CS_N] == `DPM_CS_ACTIVE) & b_read_dir;
            b_out_q <= b_sync_q[`DPM_PIN_SEL] ? a_to_b_mailbox_q
                                              : i_port_b_fifo_word;
        end
    end

    // Bus outputs straight from flip-flops
    assign o_port_a_bus    = a_out_q;
    assign o_port_a_bus_oe = a_oe_q;
    assign o_port_b_bus    = b_out_q;
    assign o_port_b_bus_oe = b_oe_q;

endmodule : dpm_mailbox_top

// ===== tb/dpm_mailbox_chk.sv
module dpm_mailbox_chk
    import dpm_pkg::*;
(
    input wire logic      i_clk_sys,
    input wire logic      i_nrst,
    input wire logic      i_port_a_chip_select_n,
    input wire logic      i_port_a_direction,
    input wire logic      i_port_a_transfer_strobe,
    input wire logic      i_port_a_mailbox_select,
    input wire dpm_word_t i_port_a_fifo_word,
    input wire dpm_word_t o_port_a_bus,
    input wire logic      o_port_a_bus_oe,
    input wire logic      o_b_to_a_mail_full_n,
    input wire logic      i_port_b_chip_select_n,
    input wire logic      i_port_b_direction,
    input wire logic      i_port_b_transfer_strobe,
    input wire logic      i_port_b_mailbox_select,
    input wire dpm_word_t o_port_b_bus,
    input wire logic      o_port_b_bus_oe,
    input wire logic      o_a_to_b_mail_full_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================
    // Flag, mailbox, FIFO path and bus drive checks
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    reset_flags_a: assert property ($rose(i_nrst) |->
        o_a_to_b_mail_full_n && o_b_to_a_mail_full_n) else $error("flag low after reset");
    ab_set_a: assert property ($fell(o_a_to_b_mail_full_n) |->
        $past(i_port_a_mailbox_select, 3) && $past(i_port_a_transfer_strobe, 3) &&
        !$past(i_port_a_chip_select_n, 3) && $past(i_port_a_direction, 3)) else $error("bad set");
    ab_clear_a: assert property ($rose(o_a_to_b_mail_full_n) |->
        $past(i_port_b_mailbox_select, 3) && $past(i_port_b_transfer_strobe, 3) &&
        !$past(i_port_b_chip_select_n, 3) && $past(i_port_b_direction, 3)) else $error("bad clr");
    ba_set_a: assert property ($fell(o_b_to_a_mail_full_n) |->
        $past(i_port_b_mailbox_select, 3) && $past(i_port_b_transfer_strobe, 3) &&
        !$past(i_port_b_chip_select_n, 3) && !$past(i_port_b_direction, 3)) else $error("bad set");
    ba_clear_a: assert property ($rose(o_b_to_a_mail_full_n) |->
        $past(i_port_a_mailbox_select, 3) && $past(i_port_a_transfer_strobe, 3) &&
        !$past(i_port_a_chip_select_n, 3) && !$past(i_port_a_direction, 3)) else $error("bad clr");
    ab_hold_a: assert property ((!o_a_to_b_mail_full_n && i_port_b_mailbox_select)[*6] |->
        $stable(o_port_b_bus)) else $error("a_to_b word changed while full");
    ba_hold_a: assert property ((!o_b_to_a_mail_full_n && i_port_a_mailbox_select)[*6] |->
        $stable(o_port_a_bus)) else $error("b_to_a word changed while full");
    fifo_path_a: assert property ((!i_port_a_mailbox_select && $stable(i_port_a_fifo_word))[*5] |->
        o_port_a_bus == i_port_a_fifo_word) else $error("port A bus not fifo word");
    a_drive_a: assert property (o_port_a_bus_oe ==
        (!$past(i_port_a_chip_select_n, 3) && !$past(i_port_a_direction, 3)))
        else $error("port A bus drive wrong");
    b_drive_a: assert property (o_port_b_bus_oe ==
        (!$past(i_port_b_chip_select_n, 3) && $past(i_port_b_direction, 3)))
        else $error("port B bus drive wrong");
endmodule : dpm_mailbox_chk

bind dpm_mailbox_top dpm_mailbox_chk u_chk (.*);

// ===== tb/dpm_port_drv.sv
module dpm_port_drv
    import dpm_pkg::*;
#(
    parameter int HALF = 4,
    parameter bit WR   = 1'b1
)(
    input  wire logic i_clk_sys,
    output logic      o_clock,
    output logic      o_cs_n,
    output logic      o_dir,
    output logic      o_stb,
    output logic      o_sel,
    output dpm_word_t o_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    // Free-running port clock, idle controls
    initial begin
        o_clock = 1'b0;
        o_cs_n = 1'b1;
        o_dir = ~WR;
        o_stb = 1'b0;
        o_sel = 1'b0;
        o_bus = '0;
        forever begin
            repeat (HALF) @(negedge i_clk_sys);
            o_clock = ~o_clock;
        end
    end
    // One access: held over a full low and high phase
    task access(input bit wr, input dpm_word_t d, input bit sel);
        @(negedge o_clock);
        o_cs_n = 1'b0;
        o_dir = wr ? WR : ~WR;
        o_stb = 1'b1;
        o_sel = sel;
        o_bus = d;
        @(negedge o_clock);
        o_cs_n = 1'b1;
        o_stb = 1'b0;
        o_bus = ~d; // Released bus no longer shows the word
    endtask : access
endmodule : dpm_port_drv

// ===== tb/tb.sv
module tb
    import dpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0;
    logic i_port_a_clock, i_port_a_chip_select_n, i_port_a_direction, i_port_a_transfer_strobe;
    logic i_port_b_clock, i_port_b_chip_select_n, i_port_b_direction, i_port_b_transfer_strobe;
    logic i_port_a_mailbox_select, i_port_b_mailbox_select, o_port_a_bus_oe, o_port_b_bus_oe;
    logic o_a_to_b_mail_full_n, o_b_to_a_mail_full_n;
    dpm_word_t i_port_a_bus, i_port_b_bus, o_port_a_bus, o_port_b_bus, w, mem[2];
    dpm_word_t i_port_a_fifo_word = '0, i_port_b_fifo_word = '0;
    int err_total = 0, cmp_count = 0, seed = 44, full[2] = '{0, 0};
    // ==============================
    // Clock, design and port masters
    always #2.5 i_clk_sys = ~i_clk_sys;
    dpm_mailbox_top dut (.*);
    dpm_port_drv #(.HALF(4), .WR(1'b1)) pa (.i_clk_sys(i_clk_sys), .o_clock(i_port_a_clock),
        .o_cs_n(i_port_a_chip_select_n), .o_dir(i_port_a_direction),
        .o_stb(i_port_a_transfer_strobe), .o_sel(i_port_a_mailbox_select), .o_bus(i_port_a_bus));
    dpm_port_drv #(.HALF(5), .WR(1'b0)) pb (.i_clk_sys(i_clk_sys), .o_clock(i_port_b_clock),
        .o_cs_n(i_port_b_chip_select_n), .o_dir(i_port_b_direction),
        .o_stb(i_port_b_transfer_strobe), .o_sel(i_port_b_mailbox_select), .o_bus(i_port_b_bus));
    // ==============================
    // Compare, access and model tasks
    task chk(input dpm_word_t got, input dpm_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk_all;
        chk(36'(o_a_to_b_mail_full_n), 36'(full[0] == 0));
        chk(36'(o_b_to_a_mail_full_n), 36'(full[1] == 0));
        chk(o_port_b_bus, i_port_b_mailbox_select ? mem[0] : i_port_b_fifo_word);
        chk(o_port_a_bus, i_port_a_mailbox_select ? mem[1] : i_port_a_fifo_word);
        chk(36'(o_port_a_bus_oe), 36'(!i_port_a_chip_select_n && !i_port_a_direction));
        chk(36'(o_port_b_bus_oe), 36'(!i_port_b_chip_select_n && i_port_b_direction));
    endtask : chk_all
    task acc(input bit src_a, input bit wr, input dpm_word_t d, input bit sel);
        if (src_a) pa.access(wr, d, sel);
        else pb.access(wr, d, sel);
        if (sel && wr && full[!src_a] == 0) begin
            mem[!src_a] = d;
            full[!src_a] = 1;
        end
        if (sel && !wr) full[src_a] = 0;
        repeat (5) @(negedge i_clk_sys);
        chk_all;
    endtask : acc
    task close_out;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // ==============================
    // Main sequence and watchdog
    initial begin
        mem = '{'0, '0};
        repeat (5) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk_all;
        for (int i = 0; i < 6; i++) begin
            i_port_a_fifo_word = 36'({$random(seed), $random(seed)});
            i_port_b_fifo_word = 36'({$random(seed), $random(seed)});
            w = 36'({$random(seed), $random(seed)});
            acc(i[0], 1'b1, w, 1'b1);
            if (i >= 2) acc(i[0], 1'b1, ~w, 1'b1);
            acc(!i[0], 1'b0, w, 1'b1);
            acc(!i[0], 1'b0, w, 1'b1);
            acc(!i[0], 1'b0, w, 1'b0);
        end
        acc(1'b1, 1'b1, w, 1'b1);
        i_nrst = 1'b0;
        @(negedge i_clk_sys);
        full = '{0, 0};
        mem = '{'0, '0};
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk_all;
        close_out;
    end
    initial begin
        #20000;
        err_total++;
        close_out;
    end
endmodule : tb
